/* File: hw/piolc_top.sv */
// parallel io line controller with ahb-lite register slave
`timescale 1ns/1ps
// Contract
// - up to 32 lines, one bit each
// - ownership enable sets, disable clears status
// - unmuxed lines ignore ownership, read 1
// - ownership reset value is a parameter
// - a-select clears, b-select sets ab bit
// - selection switches only output path
// - ab status resets to zero
// - ab writes act regardless of ownership
// - owned by peripheral, peripheral drives pin
// - output enable set and clear status
// - level set and clear status
// - output writes act under peripheral ownership
// - direct level write honours write mask
// - write mask set, clear, resets zero
// - pullup enable clears, disable sets status
// - pullup any ownership, resets zero
// - open-drain set/clear, only pulls low
// - open-drain any ownership, resets zero
// - config writes work with clock gated
// - pin reads need gated clock running
// - interrupt only while gated clock on
// - gated clock off after reset
// - undefined line bits ignored, read zero
module piolc_top #(
    parameter logic [31:0] LINE_MASK = 32'hFFFF_FFFF,
    parameter logic [31:0] MUX_MASK  = 32'hFFFF_FFFF,
    parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // gated controller clock enable and interrupt
    input  wire logic        pclk_gate_en,
    input  wire logic        irq_src,
    output logic             irq,
    // peripheral functions
    input  wire logic [31:0] pa_out,
    input  wire logic [31:0] pa_oe,
    input  wire logic [31:0] pb_out,
    input  wire logic [31:0] pb_oe,
    output logic [31:0]      periph_in,
    // pads
    input  wire logic [31:0] pad_in,
    output piolc_pkg::piolc_pad_t pad
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0] own_r, ab_r, oe_r, lvl_r, pu_r, od_r, wm_r;
    logic [31:0] sync1_r, sync2_r, pin_r;
    logic        pgate_r;
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] wdat;

    // registers exist only for defined lines
    function automatic logic [31:0] upd(input logic [31:0] cur, input logic [31:0] s,
                                        input logic [31:0] c);
        upd = ((cur | s) & ~c) & LINE_MASK;
    endfunction : upd

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = wr_pend_r && (a == ofs);
    endfunction : hit

    assign wdat = hwdata & LINE_MASK;

    ////////////////////////////////////////////////////////////////////////
    // write strobes, data word on a hit, zero otherwise
    function automatic logic [31:0] wsel(input logic [11:0] ofs);
        wsel = hit(wr_addr_r, ofs) ? wdat : 32'h0000_0000;
    endfunction : wsel

    logic [31:0] own_set;
    logic [31:0] own_clr;
    logic [31:0] ab_set;
    logic [31:0] ab_clr;
    logic [31:0] oe_set;
    logic [31:0] oe_clr;
    logic [31:0] lvl_set;
    logic [31:0] lvl_clr;
    logic [31:0] wm_set;
    logic [31:0] wm_clr;
    logic [31:0] pu_set;
    logic [31:0] pu_clr;
    logic [31:0] od_set;
    logic [31:0] od_clr;

    assign own_set = wsel(piolc_pkg::OWN_ENABLE_OFS);
    assign own_clr = wsel(piolc_pkg::OWN_DISABLE_OFS);
    assign ab_set  = wsel(piolc_pkg::PB_SELECT_OFS);
    assign ab_clr  = wsel(piolc_pkg::PA_SELECT_OFS);
    assign oe_set  = wsel(piolc_pkg::OE_SET_OFS);
    assign oe_clr  = wsel(piolc_pkg::OE_CLEAR_OFS);
    assign lvl_set = wsel(piolc_pkg::LVL_SET_OFS);
    assign lvl_clr = wsel(piolc_pkg::LVL_CLEAR_OFS);
    assign wm_set  = wsel(piolc_pkg::WM_ENABLE_OFS);
    assign wm_clr  = wsel(piolc_pkg::WM_DISABLE_OFS);
    assign pu_set  = wsel(piolc_pkg::PU_DISABLE_OFS);
    assign pu_clr  = wsel(piolc_pkg::PU_ENABLE_OFS);
    assign od_set  = wsel(piolc_pkg::OD_ENABLE_OFS);
    assign od_clr  = wsel(piolc_pkg::OD_DISABLE_OFS);

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture, zero wait states
    logic addr_ok;
    assign addr_ok = hsel && hready && (htrans == piolc_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
        end else if (clk_en) begin
            wr_pend_r <= addr_ok && hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_r <= 12'h000;
        end else if (clk_en) begin
            wr_addr_r <= haddr[11:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response: no wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else if (clk_en) begin
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers, written on hclk regardless of gating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_r <= (OWN_RESET | ~MUX_MASK) & LINE_MASK;
        end else if (clk_en) begin
            own_r <= upd(own_r,
                         own_set,
                         own_clr)
                     | (~MUX_MASK & LINE_MASK);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ab_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            ab_r <= upd(ab_r,
                        ab_set,
                        ab_clr)
                    & MUX_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            oe_r <= upd(oe_r,
                        oe_set,
                        oe_clr);
        end
    end

    logic [31:0] lvl_direct;
    assign lvl_direct = hit(wr_addr_r, piolc_pkg::LVL_STATUS_OFS) ? wm_r : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            lvl_r <= upd((lvl_r & ~lvl_direct) | (wdat & lvl_direct),
                         lvl_set,
                         lvl_clr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wm_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            wm_r <= upd(wm_r,
                        wm_set,
                        wm_clr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            pu_r <= upd(pu_r,
                        pu_set,
                        pu_clr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            od_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            od_r <= upd(od_r,
                        od_set,
                        od_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gated controller clock, input sampling and interrupt
    // gate flop, off after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgate_r <= 1'b0;
        end else if (clk_en) begin
            pgate_r <= pclk_gate_en;
        end
    end

    // two-flop synchroniser for the pin levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= piolc_pkg::ZERO_RST;
            sync2_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // pin level, held while the gate is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_r <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            if (pgate_r) begin
                pin_r <= sync2_r & LINE_MASK;
            end
        end
    end

    // interrupt passes only with the gate on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= irq_src && pgate_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad drive: ownership, peripheral mux, open drain
    logic [31:0] drv_out, drv_oe;
    for (genvar i = 0; i < piolc_pkg::NLINES; i++) begin : g_line
        logic mux_out;
        logic mux_oe;
        logic sel_out;
        logic sel_oe;
        // peripheral b when the ab bit is set, else a
        assign mux_out = ab_r[i] ? pb_out[i] : pa_out[i];
        assign mux_oe  = ab_r[i] ? pb_oe[i] : pa_oe[i];
        // controller-owned lines drive status level and enable
        assign sel_out = own_r[i] ? lvl_r[i] : mux_out;
        assign sel_oe  = own_r[i] ? oe_r[i] : mux_oe;
        // open drain: a driven one releases the pin
        assign drv_out[i] = sel_out;
        assign drv_oe[i]  = sel_oe && !(od_r[i] && sel_out);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad <= '0;
        end else if (clk_en) begin
            pad.out       <= drv_out & LINE_MASK;
            pad.oe        <= drv_oe & LINE_MASK;
            pad.pullup_en <= ~pu_r & LINE_MASK;
        end
    end

    // both peripherals see the pin, whatever the selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_in <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            periph_in <= sync2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the address phase
    logic [31:0] rd_mux;
    always_comb begin
        case (haddr[11:0])
            piolc_pkg::OWN_STATUS_OFS: rd_mux = own_r;
            piolc_pkg::AB_STATUS_OFS:  rd_mux = ab_r;
            piolc_pkg::OE_STATUS_OFS:  rd_mux = oe_r;
            piolc_pkg::LVL_STATUS_OFS: rd_mux = lvl_r;
            piolc_pkg::PIN_STATUS_OFS: rd_mux = pin_r;
            piolc_pkg::PU_STATUS_OFS:  rd_mux = pu_r;
            piolc_pkg::OD_STATUS_OFS:  rd_mux = od_r;
            piolc_pkg::WM_STATUS_OFS:  rd_mux = wm_r;
            default:                   rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= piolc_pkg::ZERO_RST;
        end else if (clk_en) begin
            hrdata <= (addr_ok && !hwrite) ? (rd_mux & LINE_MASK) : 32'h0000_0000;
        end
    end

endmodule : piolc_top

/* File: include/piolc_pkg.sv */
// package for the parallel io line controller
package piolc_pkg;
    localparam int          NLINES          = 32;
    // register byte offsets
    localparam logic [11:0] OWN_ENABLE_OFS  = 12'h000;
    localparam logic [11:0] OWN_DISABLE_OFS = 12'h004;
    localparam logic [11:0] OWN_STATUS_OFS  = 12'h008;
    localparam logic [11:0] OE_SET_OFS      = 12'h010;
    localparam logic [11:0] OE_CLEAR_OFS    = 12'h014;
    localparam logic [11:0] OE_STATUS_OFS   = 12'h018;
    localparam logic [11:0] LVL_SET_OFS     = 12'h030;
    localparam logic [11:0] LVL_CLEAR_OFS   = 12'h034;
    localparam logic [11:0] LVL_STATUS_OFS  = 12'h038;
    localparam logic [11:0] PIN_STATUS_OFS  = 12'h03C;
    localparam logic [11:0] PU_ENABLE_OFS   = 12'h060;
    localparam logic [11:0] PU_DISABLE_OFS  = 12'h064;
    localparam logic [11:0] PU_STATUS_OFS   = 12'h068;
    localparam logic [11:0] OD_ENABLE_OFS   = 12'h050;
    localparam logic [11:0] OD_DISABLE_OFS  = 12'h054;
    localparam logic [11:0] OD_STATUS_OFS   = 12'h058;
    localparam logic [11:0] PA_SELECT_OFS   = 12'h070;
    localparam logic [11:0] PB_SELECT_OFS   = 12'h074;
    localparam logic [11:0] AB_STATUS_OFS   = 12'h078;
    localparam logic [11:0] WM_ENABLE_OFS   = 12'h0A0;
    localparam logic [11:0] WM_DISABLE_OFS  = 12'h0A4;
    localparam logic [11:0] WM_STATUS_OFS   = 12'h0A8;
    // reset values and ahb bus codes
    localparam logic [31:0] ZERO_RST        = 32'h0000_0000;
    localparam logic [31:0] ONES_RST        = 32'hFFFF_FFFF;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    // per-line pin drive bundle
    typedef struct packed {
        logic [31:0] out;
        logic [31:0] oe;
        logic [31:0] pullup_en;
    } piolc_pad_t;
endpackage : piolc_pkg

/* File: verification/piolc_far_side.sv */
// pins and peripheral a/b model
`timescale 1ns/1ps
module piolc_far_side (
    // clock and pattern
    input wire logic                  hclk,
    input wire logic                  mode,
    // pads and peripherals
    input wire piolc_pkg::piolc_pad_t pad,
    output logic [31:0]               pad_in,
    output logic [31:0]               pa_out,
    output logic [31:0]               pa_oe,
    output logic [31:0]               pb_out,
    output logic [31:0]               pb_oe
);
    logic [31:0] last_r = 32'h0000_0000;
    // mode 0: a drives line 0 high; mode 1: only b drives line 0
    assign {pa_out, pa_oe, pb_out, pb_oe} = mode ? {32'h0, 32'h0, 32'h1, 32'h1}
                                                 : {32'h1, 32'h1, 32'h0, 32'hFFFF_FFFF};
    // floating lines without pull-up change every cycle
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & (pad.pullup_en | ~last_r));
    always_ff @(posedge hclk) begin
        last_r <= pad_in;
    end
endmodule : piolc_far_side

/* File: verification/piolc_properties.sv */
// port checker for the io line controller
`timescale 1ns/1ps
module piolc_chk (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // gate, interrupt, lines
    input wire logic        pclk_gate_en,
    input wire logic        irq_src,
    input wire logic        irq,
    input wire logic [31:0] pad_in,
    input wire logic [31:0] periph_in
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd;
    assign rd = hsel && htrans == piolc_pkg::HTRANS_NONSEQ && !hwrite;
    ////////////////////////////////////////////////////////////////
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
        else $error("hrdata not zero outside read");
    a_unmapped_zero: assert property (rd && haddr[11:0] inside {12'h000, 12'h00C} |=>
        hrdata == 32'h0) else $error("write-only or unmapped read not zero");
    a_irq_gated: assert property (irq |-> $past(pclk_gate_en, 2))
        else $error("irq without gated clock");
    a_irq_follow: assert property ($past(hresetn, 2) |->
        irq == ($past(irq_src) && $past(pclk_gate_en, 2))) else $error("irq wrong");
    a_gate_off_rst: assert property ($rose(hresetn) |-> !irq ##1 !irq)
        else $error("gate on after reset");
    a_periph_in: assert property ($past(hresetn) && $past(hresetn, 2) && $past(hresetn, 3)
        |-> periph_in == $past(pad_in, 3))
        else $error("periph_in not pad level");
endmodule : piolc_chk
bind piolc_top piolc_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pclk_gate_en(pclk_gate_en), .irq_src(irq_src), .irq(irq), .pad_in(pad_in),
    .periph_in(periph_in));

/* File: verification/tb_top.sv */
// self-checking bench for the io line controller
`timescale 1ns/1ps
module tb_top;
    localparam logic [31:0] LINES = 32'h7FFF_FFFF;
    localparam logic [31:0] MUXED = 32'hFFFF_FF0F;
    localparam logic [31:0] OWNRS = 32'hFFFF_FFFE;
    localparam logic [31:0] P = 32'hC000_00F3;
    localparam logic [31:0] Q = 32'h8000_0031;
    typedef struct packed {
        logic [11:0] t;
        logic        v;
        logic [31:0] r;
        logic [31:0] o;
        logic [31:0] z;
    } piolc_row_t;
    logic                  hclk, hresetn, hsel, hwrite, pclk_gate_en, irq_src, mode;
    logic                  hreadyout, hresp, irq, rdy_q;
    logic [1:0]            htrans;
    logic [31:0]           haddr, hwdata, hrdata, pad_in, pa_out, pa_oe, pb_out, pb_oe;
    logic [31:0]           periph_in, rd_q, got, eo, ev, e, m;
    piolc_pkg::piolc_pad_t pad;
    piolc_row_t            rows [7];
    int                    err_total, n_compared, cyc;
    piolc_top #(.LINE_MASK(LINES), .MUX_MASK(MUXED), .OWN_RESET(OWNRS)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(piolc_pkg::HSIZE_WORD), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pclk_gate_en(pclk_gate_en), .irq_src(irq_src), .irq(irq), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .periph_in(periph_in),
        .pad_in(pad_in), .pad(pad));
    piolc_far_side i_far (.hclk(hclk), .mode(mode), .pad(pad), .pad_in(pad_in),
        .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe));
    ////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // bus answers as seen before each edge, plus the hang limit
    always @(posedge hclk) begin
        rdy_q <= hreadyout;
        rd_q  <= hrdata;
        cyc   <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic wt();
        do begin
            @(posedge hclk);
            #1;
        end while (rdy_q !== 1'b1);
    endtask : wt
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= piolc_pkg::HTRANS_NONSEQ;
        wt();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        got = rd_q;
    endtask : ahb
    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : cmp
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        ahb(1'b0, a, 32'h0);
        cmp($sformatf("register %h", a), x, got);
    endtask : rdc
    task automatic chk_pad(input logic [31:0] own, ab, oe, lv, od);
        logic [31:0] po, pe;
        repeat (2) @(posedge hclk);
        #1;
        po = (ab & pb_out) | (~ab & pa_out);
        pe = (ab & pb_oe) | (~ab & pa_oe);
        ev = (own & lv) | (~own & po);
        eo = ((own & oe) | (~own & pe)) & ~(od & ev) & LINES;
        cmp("pad oe", eo, pad.oe);
        cmp("pad out", ev & eo, pad.out & pad.oe);
    endtask : chk_pad
    ////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, pclk_gate_en, irq_src, mode} = 6'h0;
        {haddr, hwdata, htrans} = 66'h0;
        {err_total, n_compared, cyc} = 0;
        rows = '{'{piolc_pkg::OWN_STATUS_OFS, 1'b0, (OWNRS | ~MUXED) & LINES, ~MUXED & LINES, 0},
                 '{piolc_pkg::OE_STATUS_OFS, 1'b0, 0, 0, 0},
                 '{piolc_pkg::LVL_STATUS_OFS, 1'b0, 0, 0, 0},
                 '{piolc_pkg::OD_STATUS_OFS, 1'b0, 0, 0, 0},
                 '{piolc_pkg::PU_STATUS_OFS, 1'b1, 0, 0, 0},
                 '{piolc_pkg::AB_STATUS_OFS, 1'b1, 0, 0, ~MUXED & LINES},
                 '{piolc_pkg::WM_STATUS_OFS, 1'b0, 0, 0, 0}};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        foreach (rows[i]) begin
            e = rows[i].r;
            rdc(rows[i].t, e);
            ahb(1'b1, rows[i].t - (rows[i].v ? 12'h4 : 12'h8), P);
            e = ((e | P) & LINES & ~rows[i].z) | rows[i].o;
            rdc(rows[i].t, e);
            ahb(1'b1, rows[i].t - (rows[i].v ? 12'h8 : 12'h4), Q);
            e = (e & ~Q & LINES & ~rows[i].z) | rows[i].o;
            rdc(rows[i].t, e);
        end
        $display("test set and clear registers done");
        ahb(1'b1, piolc_pkg::WM_DISABLE_OFS, 32'hFFFF_FFFF);
        ahb(1'b1, piolc_pkg::WM_ENABLE_OFS, 32'h0000_000F);
        ahb(1'b1, piolc_pkg::LVL_STATUS_OFS, 32'hFFFF_FF05);
        rdc(piolc_pkg::LVL_STATUS_OFS, 32'h4000_00C5);
        rdc(12'h00C, 32'h0);
        rdc(piolc_pkg::OWN_ENABLE_OFS, 32'h0);
        $display("test masked write done");
        ahb(1'b1, piolc_pkg::OE_SET_OFS, 32'hFFFF_FFFF);
        rdc(piolc_pkg::OE_STATUS_OFS, LINES);
        chk_pad(32'h7FFF_FFFE, 32'h4000_0002, LINES, 32'h4000_00C5, 32'h4000_00C2);
        mode <= 1'b1;
        ahb(1'b1, piolc_pkg::PB_SELECT_OFS, 32'h0000_0001);
        ahb(1'b1, piolc_pkg::OD_ENABLE_OFS, 32'h0000_0001);
        chk_pad(32'h7FFF_FFFE, 32'h4000_0003, LINES, 32'h4000_00C5, 32'h4000_00C3);
        $display("test pad drive done");
        irq_src <= 1'b1;
        rdc(piolc_pkg::PIN_STATUS_OFS, 32'h0);
        cmp("irq", 32'h0, {31'h0, irq});
        pclk_gate_en <= 1'b1;
        repeat (6) @(posedge hclk);
        #1;
        m = (eo | ~32'h4000_00C2) & LINES;
        ahb(1'b0, piolc_pkg::PIN_STATUS_OFS, 32'h0);
        cmp("pin level", ((eo & ev) | (~eo & ~32'h4000_00C2)) & m, got & m);
        cmp("irq", 32'h1, {31'h0, irq});
        $display("test clock gate done");
        hresetn <= 1'b0;
        pclk_gate_en <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        cmp("pullups", LINES, pad.pullup_en & LINES);
        rdc(piolc_pkg::OWN_STATUS_OFS, 32'h7FFF_FFFE);
        rdc(piolc_pkg::PIN_STATUS_OFS, 32'h0);
        $display("test second reset done");
        give_verdict();
    end
endmodule : tb_top
